// *** iec_one_regs.svh ***
// Register offsets, field positions and reset values of the enable block
`ifndef IEC_ONE_REGS_SVH
`define IEC_ONE_REGS_SVH

// ****************************************************
// Register map
// ****************************************************
`define IEC_ADDR_W             4
`define IEC_ENABLE_ONE_OFS     4'h0
`define IEC_PENDING_OFS        4'h4
`define IEC_FLAG_OFS           4'h8

// ****************************************************
// Field positions
// ****************************************************
`define IEC_UART2_TX_BIT       15
`define IEC_UART2_RX_BIT       14
`define IEC_EXT2_BIT           13
`define IEC_TMR5_BIT           12
`define IEC_TMR4_BIT           11
`define IEC_OC4_BIT            10
`define IEC_OC3_BIT            9
`define IEC_GAP_HI_BIT         8
`define IEC_IC8_BIT            7
`define IEC_IC7_BIT            6
`define IEC_GAP_LO_BIT         5
`define IEC_EXT1_BIT           4
`define IEC_CHG_BIT            3
`define IEC_CMP_BIT            2
`define IEC_I2C1_MST_BIT       1
`define IEC_I2C1_SLV_BIT       0

// ****************************************************
// Reset values and masks
// ****************************************************
`define IEC_ENABLE_ONE_RST     16'h0000
`define IEC_IMPL_MASK          16'hfedf

`endif

// *** iec_pkg.sv ***
// Types shared by the enable register block
package iec_pkg;

  // Avalon-MM request bundle
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } iec_bus_req_t;

  // Sixteen bit positions for the fourteen source lines
  typedef logic [15:0] iec_vec_t;

endpackage : iec_pkg

// *** iec_gate.sv ***
// Per-source gating of flags by enables
`timescale 1ns/10ps
`include "iec_one_regs.svh"

module iec_gate (
  // Sources
  input  wire iec_pkg::iec_vec_t flag_i,
  input  wire iec_pkg::iec_vec_t enable_i,
  // Gated requests
  output iec_pkg::iec_vec_t      request_o
);

  // Request only where flag and enable are both set
  always_comb begin
    request_o = flag_i & enable_i & `IEC_IMPL_MASK;
  end

endmodule : iec_gate

// *** iec_enable_one.sv ***
// Interrupt enable register one with its Avalon-MM slave
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
`include "iec_one_regs.svh"

module iec_enable_one (
  // Clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_N_I,
  // Avalon-MM slave
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  output logic      [1:0]  AVS_RESPONSE_O,
  // Source flags in named order
  input  wire logic        UART_TWO_TX_FLAG_I,
  input  wire logic        UART_TWO_RX_FLAG_I,
  input  wire logic        EXT_IRQ_TWO_FLAG_I,
  input  wire logic        TIMER_FIVE_FLAG_I,
  input  wire logic        TIMER_FOUR_FLAG_I,
  input  wire logic        OUT_CMP_FOUR_FLAG_I,
  input  wire logic        OUT_CMP_THREE_FLAG_I,
  input  wire logic        IN_CAP_EIGHT_FLAG_I,
  input  wire logic        IN_CAP_SEVEN_FLAG_I,
  input  wire logic        EXT_IRQ_ONE_FLAG_I,
  input  wire logic        CHANGE_NOTIFY_FLAG_I,
  input  wire logic        COMPARATOR_FLAG_I,
  input  wire logic        I2C_ONE_MASTER_FLAG_I,
  input  wire logic        I2C_ONE_SLAVE_FLAG_I,
  // Enable levels and gated requests, by bit position
  output logic      [15:0] ENABLE_O,
  output logic      [15:0] REQUEST_O
);

  // ****************************************************
  // Reset synchroniser
  // ****************************************************
  logic       rst_meta_reg;
  logic       rst_n_reg;

  // Async assert, two-flop release
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ****************************************************
  // Bus request and handshake
  // ****************************************************
  iec_pkg::iec_bus_req_t req;
  iec_pkg::iec_vec_t     flag_vec;
  iec_pkg::iec_vec_t     request_vec;
  logic [15:0]           interrupt_enable_one_reg;
  logic [15:0]           interrupt_enable_one_next;
  logic                  ack_reg;
  logic [31:0]           rdata_reg;
  logic                  hit;
  logic                  mapped;

  // Bundle the bus inputs
  assign req = '{address:    AVS_ADDRESS_I,
                 read:       AVS_READ_I,
                 write:      AVS_WRITE_I,
                 byteenable: AVS_BYTEENABLE_I,
                 writedata:  AVS_WRITEDATA_I};

  // Decode whether the word address holds a register
  function automatic logic is_mapped(input logic [3:0] addr);
    is_mapped = (addr == `IEC_ENABLE_ONE_OFS) ||
                (addr == `IEC_PENDING_OFS)    ||
                (addr == `IEC_FLAG_OFS);
  endfunction : is_mapped

  assign hit    = (req.read || req.write) && !ack_reg;
  assign mapped = is_mapped(req.address);

  // One wait cycle, then the acknowledging cycle
  always_ff @(posedge CLK_SYS_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= hit;
    end
  end

  // Waitrequest drops in the acknowledging cycle
  assign AVS_WAITREQUEST_O = (req.read || req.write) && !ack_reg;

  // ****************************************************
  // Enable register
  // ****************************************************

  // Byte-lane merge; unimplemented bits stay zero
  always_comb begin
    interrupt_enable_one_next = interrupt_enable_one_reg;
    if (req.byteenable[0]) begin
      interrupt_enable_one_next[7:0] = req.writedata[7:0];
    end
    if (req.byteenable[1]) begin
      interrupt_enable_one_next[15:8] = req.writedata[15:8];
    end
    interrupt_enable_one_next =
      interrupt_enable_one_next & `IEC_IMPL_MASK;
  end

  // Write takes effect on the acknowledging edge
  always_ff @(posedge CLK_SYS_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      interrupt_enable_one_reg <= `IEC_ENABLE_ONE_RST;
    end else if (ack_reg && req.write &&
                 req.address == `IEC_ENABLE_ONE_OFS) begin
      interrupt_enable_one_reg <= interrupt_enable_one_next;
    end
  end

  // ****************************************************
  // Source placement and gating
  // ****************************************************

  // Place each flag at its enable position
  always_comb begin
    flag_vec = '0;
    flag_vec[`IEC_UART2_TX_BIT]  = UART_TWO_TX_FLAG_I;
    flag_vec[`IEC_UART2_RX_BIT]  = UART_TWO_RX_FLAG_I;
    flag_vec[`IEC_EXT2_BIT]      = EXT_IRQ_TWO_FLAG_I;
    flag_vec[`IEC_TMR5_BIT]      = TIMER_FIVE_FLAG_I;
    flag_vec[`IEC_TMR4_BIT]      = TIMER_FOUR_FLAG_I;
    flag_vec[`IEC_OC4_BIT]       = OUT_CMP_FOUR_FLAG_I;
    flag_vec[`IEC_OC3_BIT]       = OUT_CMP_THREE_FLAG_I;
    flag_vec[`IEC_IC8_BIT]       = IN_CAP_EIGHT_FLAG_I;
    flag_vec[`IEC_IC7_BIT]       = IN_CAP_SEVEN_FLAG_I;
    flag_vec[`IEC_EXT1_BIT]      = EXT_IRQ_ONE_FLAG_I;
    flag_vec[`IEC_CHG_BIT]       = CHANGE_NOTIFY_FLAG_I;
    flag_vec[`IEC_CMP_BIT]       = COMPARATOR_FLAG_I;
    flag_vec[`IEC_I2C1_MST_BIT]  = I2C_ONE_MASTER_FLAG_I;
    flag_vec[`IEC_I2C1_SLV_BIT]  = I2C_ONE_SLAVE_FLAG_I;
  end

  // Gate flags with enables
  iec_gate u_gate (
    .flag_i    (flag_vec),
    .enable_i  (interrupt_enable_one_reg),
    .request_o (request_vec)
  );

  assign ENABLE_O  = interrupt_enable_one_reg;
  assign REQUEST_O = request_vec;

  // ****************************************************
  // Read data
  // ****************************************************

  // Capture read data in the wait cycle
  always_ff @(posedge CLK_SYS_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rdata_reg <= 32'h0000_0000;
    end else if (hit && req.read) begin
      unique case (req.address)
        `IEC_ENABLE_ONE_OFS: rdata_reg <= {16'h0000,
                                           interrupt_enable_one_reg};
        `IEC_PENDING_OFS:    rdata_reg <= {16'h0000, request_vec};
        `IEC_FLAG_OFS:       rdata_reg <= {16'h0000, flag_vec};
        default:             rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign AVS_READDATA_O = rdata_reg;

  // Unmapped addresses answer DECODEERROR
  assign AVS_RESPONSE_O = (ack_reg && !mapped) ? 2'h3 : 2'h0;

endmodule : iec_enable_one

// *** iec_enable_one_props.sv ***
// Assertion checker for the enable register block
`timescale 1ns/10ps
module iec_enable_one_props (
  // Clock and reset
  input wire logic        CLK_SYS_I,
  input wire logic        RST_N_I,
  // Bus and sources
  input wire logic [3:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [3:0]  AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  input wire logic        UART_TWO_TX_FLAG_I,
  input wire logic        I2C_ONE_SLAVE_FLAG_I,
  // Outputs
  input wire logic [15:0] ENABLE_O,
  input wire logic [15:0] REQUEST_O
);
  // ****************************************
  // Properties
  // ****************************************
  logic [15:0] wd_lo;
  logic        ack_en;
  // Enable register access in its ack cycle
  assign wd_lo  = AVS_WRITEDATA_I[15:0];
  assign ack_en = !AVS_WAITREQUEST_O && AVS_ADDRESS_I == 4'h0;
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_N_I);
  a_reset_clear: assert property (disable iff (1'b0)
    !RST_N_I && !$past(RST_N_I) |-> ENABLE_O == 16'h0000)
    else $error("enable set in reset");
  a_gap_bits_zero: assert property (
    !ENABLE_O[8] && !ENABLE_O[5] && !REQUEST_O[8] && !REQUEST_O[5])
    else $error("gap bit set");
  a_req_needs_en: assert property (
    (REQUEST_O & ~ENABLE_O) == 16'h0000) else $error("request w/o enable");
  a_tx_gate: assert property (
    REQUEST_O[15] == (ENABLE_O[15] && UART_TWO_TX_FLAG_I))
    else $error("tx request wrong");
  a_slv_gate: assert property (
    REQUEST_O[0] == (ENABLE_O[0] && I2C_ONE_SLAVE_FLAG_I))
    else $error("slave request wrong");
  a_write_lands: assert property (
    AVS_WRITE_I && ack_en && AVS_BYTEENABLE_I == 4'h3
    |=> ENABLE_O == ($past(wd_lo) & 16'hfedf)) else $error("write lost");
  a_en_stable: assert property (
    !(AVS_WRITE_I && ack_en) |=> $stable(ENABLE_O))
    else $error("enable moved");
  a_read_back: assert property (
    AVS_READ_I && ack_en |-> AVS_READDATA_O == {16'h0000, ENABLE_O})
    else $error("read data wrong");
endmodule : iec_enable_one_props

bind iec_enable_one iec_enable_one_props u_props (
  .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .UART_TWO_TX_FLAG_I(UART_TWO_TX_FLAG_I), .ENABLE_O(ENABLE_O),
  .I2C_ONE_SLAVE_FLAG_I(I2C_ONE_SLAVE_FLAG_I), .REQUEST_O(REQUEST_O));

// *** iec_enable_one_test.sv ***
// Self-checking bench for the enable register block
`timescale 1ns/10ps
module iec_enable_one_test;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk, rst_n, rd, wr, wt;
  logic [3:0]  adr, be;
  logic [31:0] wd, rdat, rv;
  logic [1:0]  resp, rr;
  logic [15:0] fl, en, req, e;
  int          n_errors, n_tests;
  iec_enable_one dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be),
    .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wt),
    .AVS_RESPONSE_O(resp), .UART_TWO_TX_FLAG_I(fl[15]),
    .UART_TWO_RX_FLAG_I(fl[14]), .EXT_IRQ_TWO_FLAG_I(fl[13]),
    .TIMER_FIVE_FLAG_I(fl[12]), .TIMER_FOUR_FLAG_I(fl[11]),
    .OUT_CMP_FOUR_FLAG_I(fl[10]), .OUT_CMP_THREE_FLAG_I(fl[9]),
    .IN_CAP_EIGHT_FLAG_I(fl[7]), .IN_CAP_SEVEN_FLAG_I(fl[6]),
    .EXT_IRQ_ONE_FLAG_I(fl[4]), .CHANGE_NOTIFY_FLAG_I(fl[3]),
    .COMPARATOR_FLAG_I(fl[2]), .I2C_ONE_MASTER_FLAG_I(fl[1]),
    .I2C_ONE_SLAVE_FLAG_I(fl[0]), .ENABLE_O(en), .REQUEST_O(req));
  // Clock at 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One Avalon access, held until waitrequest is low
  task automatic bus(input logic w, input logic [3:0] a, b,
                     input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    be <= b;
    wd <= d;
    do @(posedge clk); while (wt !== 1'b0);
    rv = rdat;
    rr = resp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic test_done;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  // Each bit alone, read back and gating
  task automatic t_bits;
    for (int i = 0; i < 16; i++) begin
      e = (16'h0001 << i) & 16'hfedf;
      bus(1'b1, 4'h0, 4'h3, 32'h1 << i);
      bus(1'b0, 4'h0, 4'h3, 32'h0);
      chk("readback", rv, {16'h0000, e});
      fl <= 16'hffff; // external inputs taken as routed
      @(negedge clk);
      chk("request", req, e);
      @(posedge clk);
      fl <= ~e;
      @(negedge clk);
      chk("no flag", req, 16'h0000);
    end
  endtask : t_bits
  // Lanes, read-only and unmapped places, mid-run reset
  task automatic t_misc;
    fl <= 16'hffff; // external inputs taken as routed
    bus(1'b1, 4'h0, 4'h1, 32'hffffffff);
    bus(1'b0, 4'h8, 4'h3, 32'h0);
    chk("flags", rv, 32'h0000fedf);
    chk("resp ok", rr, 32'h0);
    bus(1'b0, 4'h4, 4'h3, 32'h0);
    chk("lane0 pending", rv, 32'h000080df);
    bus(1'b1, 4'h0, 4'h2, 32'hffffffff);
    bus(1'b1, 4'h4, 4'h3, 32'h0);
    bus(1'b1, 4'hc, 4'h3, 32'h0);
    bus(1'b0, 4'hc, 4'h3, 32'h0);
    chk("unmapped", {rr, rv[29:0]}, 32'hc0000000);
    bus(1'b0, 4'h4, 4'h3, 32'h0);
    chk("pending", rv, 32'h0000fedf);
    chk("enable", en, 16'hfedf);
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    chk("reset", en, 16'h0000);
    chk("reset req", req, 16'h0000);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, 4'h0, 4'h3, 32'h0);
    chk("after reset", rv, 32'h0);
  endtask : t_misc
  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial begin
    {rst_n, rd, wr, adr, be, wd, fl, n_errors, n_tests} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("enable", en, 16'h0000);
    t_bits();
    t_misc();
    test_done();
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    test_done();
  end
endmodule : iec_enable_one_test
